/* bdsc_map.svh */
// register offsets, field positions, reset values and timing figures of the state controller
`ifndef BDSC_MAP_SVH
`define BDSC_MAP_SVH

`define BDSC_CTRL_OFFSET 8'h00
`define BDSC_STATUS_OFFSET 8'h04

`define CTRL_PWM_BIT 0
`define CTRL_LATCH_BIT 1
`define CTRL_OLP_BIT 2
`define CTRL_CLEAR_BIT 3
`define CTRL_RESET 3'h0

`define STATUS_MODE_LSB 0
`define STATUS_WAKE_DONE_BIT 3
`define STATUS_FLAG_LSB 4
`define STATUS_POR_SEEN_BIT 9
`define STATUS_OCP_PEND_BIT 10

`define FLAG_TSD 0
`define FLAG_OCP 1
`define FLAG_SUPPLY_UNDERVOLTAGE_EVENT 2
`define FLAG_SUPPLY_OVERVOLTAGE_EVENT 3
`define FLAG_OLA 4

`define PIN_SLEEP 0
`define PIN_SUPPLY_LOW 1
`define PIN_DRV_DISABLE 2
`define PIN_IN1 3
`define PIN_IN2 4
`define PIN_TSD 5
`define PIN_OCP 6
`define PIN_SUPPLY_UNDERVOLTAGE_EVENT 7
`define PIN_SUPPLY_OVERVOLTAGE_EVENT 8
`define PIN_OLA 9
`define PIN_CHOP 10
`define PIN_OLP_CMP 11
`define PIN_COUNT 12

`define CNT_W 24

`define CLOCK_PERIOD_PS 5000
`define POR_FILTER_NS 10000
`define SLEEP_DEGLITCH_NS 120000
`define WAKE_TIME_NS 30000
`define RESET_DEGLITCH_NS 20000
`define COM_READY_NS 500000
`define READY_NS 1000000
`define OCP_FILTER_NS 6000

// least times: round up to whole cycles
`define CEIL_CYCLES(tns) ((((tns) * 1000) + `CLOCK_PERIOD_PS - 1) / `CLOCK_PERIOD_PS)

`endif

/* bdsc_pkg.sv */
// types shared by the state controller and its pulse-width meter
`include "bdsc_map.svh"

package bdsc_pkg;

    typedef enum logic [2:0] {
        ST_SLEEP = 3'b000,
        ST_WAKE = 3'b001,
        ST_STANDBY = 3'b010,
        ST_ACTIVE = 3'b011,
        ST_POR = 3'b100
    } mode_t;

    typedef logic [`PIN_COUNT-1:0] pin_vec_t;

    typedef struct packed {
        logic [`CNT_W-1:0] lowCount;
        logic lastLevel;
        logic releasePulse;
        logic [`CNT_W-1:0] releaseWidth;
    } meter_state_t;

    typedef struct packed {
        pin_vec_t pinMeta;
        pin_vec_t pinSafe;
        mode_t mode;
        logic [`CNT_W-1:0] timer;
        logic [`CNT_W-1:0] porCount;
        logic [`CNT_W-1:0] ocpCount;
        logic wakeDone;
        logic porSeen;
        logic [2:0] ctrl;
        logic [4:0] flags;
        logic writePending;
        logic [7:0] addr;
        logic [31:0] rdata;
        logic [1:0] bridgeOut;
        logic [1:0] bridgeOeN;
        logic faultOeN;
        logic senseOeN;
        logic railsOn;
        logic olpActive;
    } ctl_state_t;

endpackage : bdsc_pkg

/* bridge_driver_state_control.sv */
// functional-state controller of an H-bridge driver with AHB-Lite control registers
`timescale 1ns/1ps

module bridge_driver_state_control
    import bdsc_pkg::*;
#(
    parameter int POR_CYCLES = `CEIL_CYCLES(`POR_FILTER_NS),
    parameter int SLEEP_CYCLES = `CEIL_CYCLES(`SLEEP_DEGLITCH_NS),
    parameter int WAKE_CYCLES = `CEIL_CYCLES(`WAKE_TIME_NS),
    parameter int RESET_CYCLES = `CEIL_CYCLES(`RESET_DEGLITCH_NS),
    parameter int COM_CYCLES = `CEIL_CYCLES(`COM_READY_NS),
    parameter int READY_CYCLES = `CEIL_CYCLES(`READY_NS),
    parameter int OCP_CYCLES = `CEIL_CYCLES(`OCP_FILTER_NS)
)
(
    input wire logic clock,
    input wire logic clkEnable,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic sleepRequestN,
    input wire logic supplyLow,
    input wire logic driverDisable,
    input wire logic bridgeInput1,
    input wire logic bridgeInput2,
    input wire logic overTemperatureEvent,
    input wire logic overCurrentEvent,
    input wire logic supplyUndervoltageEvent,
    input wire logic supplyOvervoltageEvent,
    input wire logic onStateOpenLoad,
    input wire logic currentRegulationChop,
    input wire logic offStateCompare,
    output logic faultIndicatorNOut,
    output logic faultIndicatorNOeN,
    output logic [1:0] bridgeOutputs,
    output logic [1:0] bridgeOutputsOeN,
    output logic currentSenseOutputOeN,
    output logic railsOn,
    output logic offStateLoadCheck,
    output logic [2:0] stateCode
);

    localparam logic [`CNT_W-1:0] POR_LIM = `CNT_W'(POR_CYCLES);
    localparam logic [`CNT_W-1:0] SLEEP_LIM = `CNT_W'(SLEEP_CYCLES);
    localparam logic [`CNT_W-1:0] WAKE_LIM = `CNT_W'(WAKE_CYCLES);
    localparam logic [`CNT_W-1:0] RESET_LIM = `CNT_W'(RESET_CYCLES);
    localparam logic [`CNT_W-1:0] COM_LIM = `CNT_W'(COM_CYCLES);
    localparam logic [`CNT_W-1:0] DONE_LIM = `CNT_W'(COM_CYCLES + READY_CYCLES);
    localparam logic [`CNT_W-1:0] OCP_LIM = `CNT_W'(OCP_CYCLES);

    ctl_state_t s;
    ctl_state_t n;
    pin_vec_t pinIn;
    logic [`CNT_W-1:0] lowCount;
    logic releasePulse;
    logic [`CNT_W-1:0] releaseWidth;
    logic sleepHeld;
    logic resetPulse;
    logic clearCmd;
    logic ackOrClear;
    logic porTrip;
    logic standbyHold;
    logic ocpConfirmed;
    logic ocpPending;
    logic [4:0] evSet;
    logic [4:0] latchMask;
    logic [2:0] drive;
    logic addrTaken;

    // {drive active, out2, out1}; PWM drives both halves directly, PH/EN steers by phase
    function automatic logic [2:0] bridgeDecode(input logic pwm, input logic in1,
                                               input logic in2);
        if (pwm)
        begin
            return {in1 | in2, in2, in1};
        end
        return {in1, in2, ~in2};
    endfunction : bridgeDecode

    function automatic logic [31:0] readMux(input logic [7:0] offset, input ctl_state_t cur);
        logic [31:0] value;
        value = 32'h0000_0000;
        if (offset == `BDSC_CTRL_OFFSET)
        begin
            value[2:0] = cur.ctrl;
        end
        else if (offset == `BDSC_STATUS_OFFSET)
        begin
            value[`STATUS_MODE_LSB +: 3] = cur.mode;
            value[`STATUS_WAKE_DONE_BIT] = cur.wakeDone;
            value[`STATUS_FLAG_LSB +: 5] = cur.flags;
            value[`STATUS_POR_SEEN_BIT] = cur.porSeen;
            value[`STATUS_OCP_PEND_BIT] = cur.ocpCount != '0;
        end
        return value;
    endfunction : readMux

    assign pinIn = {offStateCompare, currentRegulationChop, onStateOpenLoad,
                    supplyOvervoltageEvent, supplyUndervoltageEvent, overCurrentEvent,
                    overTemperatureEvent, bridgeInput2, bridgeInput1, driverDisable,
                    supplyLow, sleepRequestN};

    low_width_meter sleepMeter (
        .clock(clock),
        .clkEnable(clkEnable),
        .rst(rst),
        .levelIn(s.pinSafe[`PIN_SLEEP]),
        .lowCount(lowCount),
        .releasePulse(releasePulse),
        .releaseWidth(releaseWidth)
    );

    always_comb
    begin
        n = s;
        n.pinMeta = pinIn;
        n.pinSafe = s.pinMeta;

        sleepHeld = lowCount >= SLEEP_LIM;
        // widths from reset minimum to sleep are a clear; shorter ones are glitches
        resetPulse = releasePulse && releaseWidth >= RESET_LIM
                     && releaseWidth < SLEEP_LIM;
        clearCmd = s.writePending && s.addr == `BDSC_CTRL_OFFSET
                   && hwdata[`CTRL_CLEAR_BIT];
        ackOrClear = resetPulse || clearCmd;
        standbyHold = !s.pinSafe[`PIN_DRV_DISABLE]
                      || (s.ctrl[`CTRL_PWM_BIT] && s.pinSafe[`PIN_IN1]
                          && s.pinSafe[`PIN_IN2]);
        ocpConfirmed = s.ocpCount >= OCP_LIM;
        ocpPending = s.pinSafe[`PIN_OCP] && !ocpConfirmed;
        drive = bridgeDecode(s.ctrl[`CTRL_PWM_BIT], s.pinSafe[`PIN_IN1],
                             s.pinSafe[`PIN_IN2]);
        addrTaken = hsel && hready && htrans[1];

        // AHB-Lite slave: zero wait states, always OKAY, read data in the data phase
        n.writePending = addrTaken && hwrite;
        n.addr = haddr[7:0];
        n.rdata = (addrTaken && !hwrite) ? readMux(haddr[7:0], s) : 32'h0000_0000;
        if (s.writePending && s.addr == `BDSC_CTRL_OFFSET)
        begin
            n.ctrl = hwdata[2:0];
        end

        // over-current filter counts only while the raw event stands
        if (s.pinSafe[`PIN_OCP] && s.mode == ST_ACTIVE)
        begin
            if (!ocpConfirmed)
            begin
                n.ocpCount = s.ocpCount + `CNT_W'(1);
            end
        end
        else
        begin
            n.ocpCount = '0;
        end

        evSet = 5'h00;
        if (s.mode == ST_STANDBY || s.mode == ST_ACTIVE)
        begin
            evSet[`FLAG_TSD] = s.pinSafe[`PIN_TSD];
            evSet[`FLAG_SUPPLY_UNDERVOLTAGE_EVENT] = s.pinSafe[`PIN_SUPPLY_UNDERVOLTAGE_EVENT];
            evSet[`FLAG_SUPPLY_OVERVOLTAGE_EVENT] = s.pinSafe[`PIN_SUPPLY_OVERVOLTAGE_EVENT];
        end
        if (s.mode == ST_ACTIVE)
        begin
            evSet[`FLAG_OCP] = ocpConfirmed;
            evSet[`FLAG_OLA] = s.pinSafe[`PIN_OLA];
        end
        // undervoltage always retries; the rest latch when configured
        latchMask = s.ctrl[`CTRL_LATCH_BIT] ? 5'b11011 : 5'b00000;
        // a new event wins over a clear in the same cycle
        n.flags = evSet | (s.flags & latchMask & {5{!ackOrClear}});

        unique case (s.mode)
            ST_POR:
            begin
                n.timer = '0;
                if (!s.pinSafe[`PIN_SUPPLY_LOW])
                begin
                    n.mode = ST_WAKE;
                    n.porSeen = 1'b1;
                end
            end
            ST_SLEEP:
            begin
                n.flags = 5'h00;
                if (s.pinSafe[`PIN_SLEEP])
                begin
                    if (s.timer != {`CNT_W{1'b1}})
                    begin
                        n.timer = s.timer + `CNT_W'(1);
                    end
                end
                else
                begin
                    n.timer = '0;
                end
                if (s.timer >= WAKE_LIM && !s.pinSafe[`PIN_SUPPLY_LOW])
                begin
                    n.mode = ST_WAKE;
                    n.timer = '0;
                    n.wakeDone = 1'b0;
                end
            end
            ST_WAKE:
            begin
                if (s.timer != {`CNT_W{1'b1}})
                begin
                    n.timer = s.timer + `CNT_W'(1);
                end
                n.wakeDone = s.timer >= DONE_LIM;
                if (sleepHeld)
                begin
                    n.mode = ST_SLEEP;
                    n.timer = '0;
                end
                else if (s.wakeDone && ackOrClear)
                begin
                    n.mode = ST_STANDBY;
                end
            end
            ST_STANDBY:
            begin
                if (sleepHeld)
                begin
                    n.mode = ST_SLEEP;
                    n.timer = '0;
                end
                else if (!standbyHold)
                begin
                    n.mode = ST_ACTIVE;
                end
            end
            ST_ACTIVE:
            begin
                // priority ladder; overvoltage and open load only reach the fault pin
                if (sleepHeld)
                begin
                    n.mode = ST_SLEEP;
                    n.timer = '0;
                end
                else if (standbyHold)
                begin
                    n.mode = ST_STANDBY;
                end
                else if (s.pinSafe[`PIN_TSD] || s.flags[`FLAG_TSD])
                begin
                    n.bridgeOeN = 2'h3;
                end
                else if (ocpConfirmed || s.flags[`FLAG_OCP])
                begin
                    n.bridgeOeN = 2'h3;
                end
                else if (ocpPending)
                begin
                    // freeze the bridge; bounded because the count confirms at the filter
                    n.bridgeOeN = s.bridgeOeN;
                end
                else if (s.pinSafe[`PIN_SUPPLY_UNDERVOLTAGE_EVENT])
                begin
                    n.bridgeOeN = 2'h3;
                end
                else if (!drive[2])
                begin
                    n.bridgeOeN = 2'h0;
                    n.bridgeOut = 2'h0;
                end
                else
                begin
                    n.bridgeOeN = 2'h0;
                    n.bridgeOut = s.pinSafe[`PIN_CHOP] ? 2'h0 : drive[1:0];
                end
            end
        endcase

        // supply below falling threshold drops to SLEEP; past the filter it hard-resets
        porTrip = s.pinSafe[`PIN_SUPPLY_LOW] && s.porCount >= POR_LIM;
        if (s.pinSafe[`PIN_SUPPLY_LOW])
        begin
            if (!porTrip)
            begin
                n.porCount = s.porCount + `CNT_W'(1);
            end
            if (s.mode != ST_POR)
            begin
                n.mode = ST_SLEEP;
                n.timer = '0;
            end
        end
        else
        begin
            n.porCount = '0;
        end
        if (porTrip)
        begin
            n.mode = ST_POR;
            n.timer = '0;
            n.ocpCount = '0;
            n.flags = 5'h00;
            n.ctrl = `CTRL_RESET;
            n.wakeDone = 1'b0;
            n.porSeen = 1'b0;
        end

        // pin drive follows the state being entered, so outputs match stateCode
        n.senseOeN = 1'b1;
        n.railsOn = 1'b1;
        n.faultOeN = 1'b1;
        n.olpActive = 1'b0;
        unique case (n.mode)
            ST_POR, ST_SLEEP:
            begin
                n.bridgeOeN = 2'h3;
                n.railsOn = 1'b0;
            end
            ST_WAKE:
            begin
                n.bridgeOeN = 2'h3;
                n.faultOeN = !(n.timer >= COM_LIM);
            end
            ST_STANDBY:
            begin
                n.bridgeOeN = 2'h3;
                n.olpActive = s.ctrl[`CTRL_OLP_BIT];
                n.faultOeN = !(n.olpActive && s.pinSafe[`PIN_OLP_CMP]);
            end
            ST_ACTIVE:
            begin
                n.senseOeN = n.bridgeOeN != 2'h0;
                n.faultOeN = !(|n.flags);
            end
        endcase
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            // the logic-supply POR drives rst; leaving it starts wake-up like any recovery
            s <= '0;
            s.mode <= ST_POR;
            s.bridgeOeN <= 2'h3;
            s.faultOeN <= 1'b1;
            s.senseOeN <= 1'b1;
            // syncs start at idle levels: no false sleep edge, supply trusted only once seen
            s.pinMeta[`PIN_SLEEP] <= 1'b1;
            s.pinSafe[`PIN_SLEEP] <= 1'b1;
            s.pinMeta[`PIN_SUPPLY_LOW] <= 1'b1;
            s.pinSafe[`PIN_SUPPLY_LOW] <= 1'b1;
        end
        else if (clkEnable)
        begin
            s <= n;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = s.rdata;
    assign faultIndicatorNOut = 1'b0;
    assign faultIndicatorNOeN = s.faultOeN;
    assign bridgeOutputs = s.bridgeOut;
    assign bridgeOutputsOeN = s.bridgeOeN;
    assign currentSenseOutputOeN = s.senseOeN;
    assign railsOn = s.railsOn;
    assign offStateLoadCheck = s.olpActive;
    assign stateCode = s.mode;

    property p_por_reset;
        @(posedge clock) disable iff (rst)
        (clkEnable && porTrip) |=> (s.mode == ST_POR && s.flags == 5'h00);
    endproperty
    a_por_reset: assert property (p_por_reset) else $error("POR trip did not reset");

    property p_por_pins;
        @(posedge clock) disable iff (rst)
        (s.mode == ST_POR) |-> (faultIndicatorNOeN && bridgeOutputsOeN == 2'h3
                                && currentSenseOutputOeN);
    endproperty
    a_por_pins: assert property (p_por_pins) else $error("pins driven during POR");

    property p_por_wake;
        @(posedge clock) disable iff (rst)
        (s.mode == ST_POR && clkEnable && !s.pinSafe[`PIN_SUPPLY_LOW]) |=> (s.mode == ST_WAKE);
    endproperty
    a_por_wake: assert property (p_por_wake) else $error("no wake after POR");

    property p_com_fault;
        @(posedge clock) disable iff (rst)
        (s.mode == ST_WAKE) |-> (faultIndicatorNOeN == (s.timer < COM_LIM));
    endproperty
    a_com_fault: assert property (p_com_fault) else $error("fault pin wrong in wake");

    property p_ack;
        @(posedge clock) disable iff (rst)
        (s.mode == ST_WAKE && s.wakeDone && resetPulse && clkEnable && !sleepHeld
         && !s.pinSafe[`PIN_SUPPLY_LOW]) |=> (s.mode == ST_STANDBY && faultIndicatorNOeN);
    endproperty
    a_ack: assert property (p_ack) else $error("acknowledge not taken");

    property p_sleep_pins;
        @(posedge clock) disable iff (rst)
        (s.mode == ST_SLEEP) |-> (bridgeOutputsOeN == 2'h3 && faultIndicatorNOeN && !railsOn);
    endproperty
    a_sleep_pins: assert property (p_sleep_pins) else $error("sleep pins wrong");

    property p_sleep_entry;
        @(posedge clock) disable iff (rst)
        ((s.mode == ST_STANDBY || s.mode == ST_ACTIVE) && sleepHeld && clkEnable && !porTrip)
        |=> (s.mode == ST_SLEEP);
    endproperty
    a_sleep_entry: assert property (p_sleep_entry) else $error("sleep not entered");

    property p_active_entry;
        @(posedge clock) disable iff (rst)
        (s.mode == ST_ACTIVE) |-> ($past(s.mode) == ST_STANDBY || $past(s.mode) == ST_ACTIVE);
    endproperty
    a_active_entry: assert property (p_active_entry) else $error("bad ACTIVE entry");

    property p_olp_standby;
        @(posedge clock) disable iff (rst)
        offStateLoadCheck |-> (s.mode == ST_STANDBY);
    endproperty
    a_olp_standby: assert property (p_olp_standby) else $error("load check off STANDBY");

endmodule : bridge_driver_state_control

/* bridge_driver_state_control_test.sv */
// self-checking bench of the bridge driver state controller
`timescale 1ns/1ps

module bridge_driver_state_control_test;
    import bdsc_pkg::*;
    logic clock = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [1:0] htrans = 2'h0, bOut, bOeN;
    logic sleepN, supLow = 1'b0, drvDis = 1'b0, in1 = 1'b0, in2 = 1'b0, over_temperature_event = 1'b0, supply_overvoltage_event = 1'b0;
    logic cmp = 1'b0, fOut, fOeN, sOeN, rails, off_state_load_check;
    logic ce = 1'b1, over_current_event = 1'b0, supply_undervoltage_event = 1'b0, on_state_open_load = 1'b0, chop = 1'b0;
    logic [2:0] hsz = 3'h0;
    logic [2:0] st;
    int failures = 0, n_tests = 0, cycles = 0;

    always #2.5 clock = ~clock;

    mcu_model i_host (.clock(clock), .sleepRequestN(sleepN));

    bridge_driver_state_control #(.POR_CYCLES(8), .SLEEP_CYCLES(64), .WAKE_CYCLES(16),
        .RESET_CYCLES(16), .COM_CYCLES(32), .READY_CYCLES(32), .OCP_CYCLES(8)) i_dut (
        .clock(clock), .clkEnable(ce), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsz), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sleepRequestN(sleepN),
        .supplyLow(supLow), .driverDisable(drvDis), .bridgeInput1(in1), .bridgeInput2(in2),
        .overTemperatureEvent(over_temperature_event), .overCurrentEvent(over_current_event), .supplyUndervoltageEvent(supply_undervoltage_event),
        .supplyOvervoltageEvent(supply_overvoltage_event), .onStateOpenLoad(on_state_open_load), .currentRegulationChop(chop),
        .offStateCompare(cmp), .faultIndicatorNOut(fOut), .faultIndicatorNOeN(fOeN),
        .bridgeOutputs(bOut), .bridgeOutputsOeN(bOeN), .currentSenseOutputOeN(sOeN),
        .railsOn(rails), .offStateLoadCheck(off_state_load_check), .stateCode(st));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            failures++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic report_and_stop();
        if (failures == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop

    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            failures++;
            report_and_stop();
        end
    end

    // single transfer; read data is taken at the edge that closes the data phase
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clock);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        hsz <= 3'h2;
        do @(posedge clock); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clock); while (hreadyout !== 1'b1);
        rd = hrdata;
        hsel <= 1'b0;
    endtask : bus

    task automatic wait_state(input logic [2:0] code);
        for (int i = 0; i < 300 && st !== code; i++) @(posedge clock);
    endtask : wait_state

    task automatic s_wake();
        check(st, 3'h4);
        check({fOeN, bOeN, sOeN}, 4'hF);
        @(posedge clock);
        rst <= 1'b0;
        wait_state(3'h1);
        check(st, 3'h1);
        for (int i = 0; i < 200 && fOeN !== 1'b0; i++) @(posedge clock);
        check({fOut, fOeN}, 2'h0);
        bus(1'b0, 32'h4, 32'h0);
        check(rd[3], 1'b0);
        repeat (40) @(posedge clock);
        bus(1'b0, 32'h4, 32'h0);
        check(rd[3], 1'b1);
        i_host.pulse_low(24);
        repeat (6) @(posedge clock);
        check({st, fOeN, bOeN}, 6'h17);
    endtask : s_wake

    task automatic s_active();
        bus(1'b0, 32'h8, 32'h0);
        check(rd, 32'h0);
        check(st, 3'h2);
        drvDis <= 1'b1;
        repeat (5) @(posedge clock);
        check(st, 3'h3);
        bus(1'b1, 32'h0, 32'h5);
        in1 <= 1'b1;
        in2 <= 1'b1;
        cmp <= 1'b1;
        repeat (5) @(posedge clock);
        check({st, off_state_load_check, fOeN}, 5'h0A);
        bus(1'b0, 32'h0, 32'h0);
        check(rd, 32'h5);
        in2 <= 1'b0;
        repeat (5) @(posedge clock);
        check({st, off_state_load_check}, 4'h6);
        over_temperature_event <= 1'b1;
        supply_overvoltage_event <= 1'b1;
        repeat (5) @(posedge clock);
        check({bOeN, fOeN}, 3'h6);
        over_temperature_event <= 1'b0;
        supply_overvoltage_event <= 1'b0;
        repeat (5) @(posedge clock);
    endtask : s_active

    task automatic s_protect();
        over_current_event <= 1'b1;
        repeat (4) @(posedge clock);
        check(bOeN, 2'h0);
        bus(1'b0, 32'h4, 32'h0);
        check(rd[10], 1'b1);
        repeat (10) @(posedge clock);
        check({bOeN, fOeN}, 3'h6);
        over_current_event <= 1'b0;
        chop <= 1'b1;
        on_state_open_load <= 1'b1;
        repeat (8) @(posedge clock);
        check({bOeN, bOut, fOeN, sOeN}, 6'h00);
        chop <= 1'b0;
        on_state_open_load <= 1'b0;
        supply_undervoltage_event <= 1'b1;
        repeat (5) @(posedge clock);
        check({bOeN, fOeN}, 3'h6);
        supply_undervoltage_event <= 1'b0;
        bus(1'b1, 32'h0, 32'h3);
        over_temperature_event <= 1'b1;
        repeat (4) @(posedge clock);
        over_temperature_event <= 1'b0;
        repeat (5) @(posedge clock);
        check({bOeN, fOeN}, 3'h6);
        i_host.pulse_low(24);
        repeat (6) @(posedge clock);
        check({st, bOeN, fOeN}, 6'h19);
        supply_overvoltage_event <= 1'b1;
        repeat (4) @(posedge clock);
        supply_overvoltage_event <= 1'b0;
        repeat (4) @(posedge clock);
        check({bOeN, fOeN}, 3'h0);
        bus(1'b1, 32'h0, 32'hB);
        repeat (2) @(posedge clock);
        check(fOeN, 1'b1);
        bus(1'b0, 32'h0, 32'h0);
        check(rd, 32'h3);
        ce <= 1'b0;
        drvDis <= 1'b0;
        repeat (5) @(posedge clock);
        check(st, 3'h3);
        ce <= 1'b1;
        repeat (5) @(posedge clock);
        check(st, 3'h2);
        drvDis <= 1'b1;
        repeat (5) @(posedge clock);
        check(st, 3'h3);
    endtask : s_protect

    task automatic s_sleep();
        i_host.pulse_low(8);
        repeat (5) @(posedge clock);
        check(st, 3'h3);
        i_host.pulse_low(100);
        repeat (2) @(posedge clock);
        check({st, rails, fOeN, bOeN}, 6'h07);
        repeat (30) @(posedge clock);
        check(st, 3'h1);
    endtask : s_sleep

    task automatic s_por();
        supLow <= 1'b1;
        repeat (20) @(posedge clock);
        check({st, fOeN, bOeN}, 6'h27);
        supLow <= 1'b0;
        repeat (10) @(posedge clock);
        check(st, 3'h1);
    endtask : s_por

    initial
    begin
        repeat (5) @(posedge clock);
        s_wake();
        s_active();
        s_protect();
        s_sleep();
        s_por();
        report_and_stop();
    end
endmodule : bridge_driver_state_control_test

/* low_width_meter.sv */
// measures how long a synchronised active-low pin stays low, reports the width on release
`timescale 1ns/1ps

module low_width_meter
    import bdsc_pkg::*;
(
    input wire logic clock,
    input wire logic clkEnable,
    input wire logic rst,
    input wire logic levelIn,
    output logic [`CNT_W-1:0] lowCount,
    output logic releasePulse,
    output logic [`CNT_W-1:0] releaseWidth
);

    meter_state_t st;
    meter_state_t next_st;

    always_comb
    begin
        next_st = st;
        next_st.lastLevel = levelIn;
        next_st.releasePulse = 1'b0;
        if (!levelIn)
        begin
            // saturate so a very long low never wraps into a short pulse
            if (st.lowCount != {`CNT_W{1'b1}})
            begin
                next_st.lowCount = st.lowCount + `CNT_W'(1);
            end
        end
        else
        begin
            next_st.lowCount = '0;
            if (!st.lastLevel)
            begin
                next_st.releasePulse = 1'b1;
                next_st.releaseWidth = st.lowCount;
            end
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            st <= '0;
            st.lastLevel <= 1'b1;
        end
        else if (clkEnable)
        begin
            st <= next_st;
        end
    end

    assign lowCount = st.lowCount;
    assign releasePulse = st.releasePulse;
    assign releaseWidth = st.releaseWidth;

endmodule : low_width_meter

/* mcu_model.sv */
// far-side controller model: drives the sleep pin with acknowledge and sleep pulses
`timescale 1ns/1ps

module mcu_model
(
    input wire logic clock,
    output logic sleepRequestN
);
    initial sleepRequestN = 1'b1;

    // the pin changes just after rising edges, so the width is exactly w cycles
    task automatic pulse_low(input int w);
        @(posedge clock);
        sleepRequestN <= 1'b0;
        repeat (w) @(posedge clock);
        sleepRequestN <= 1'b1;
    endtask : pulse_low
endmodule : mcu_model
